// File: src/hpws_defs.vh
// constants for the host port front end: styles, widths, lane decode, timing
// assumes a single 100 MHz core clock; included by the front end only, not by its synchroniser
`ifndef HPWS_DEFS_VH
`define HPWS_DEFS_VH

// ==========================================================
// strap encodings
`define HPWS_STYLE_SPLIT    1'b1
`define HPWS_STYLE_DSTROBE  1'b0
`define HPWS_WIDTH_WORD     1'b1
`define HPWS_WIDTH_BYTE     1'b0

// ==========================================================
// bus widths
`define HPWS_ADDR_W         20
`define HPWS_DATA_W         16
`define HPWS_INT_W          32

// ==========================================================
// lane positions inside the 32-bit internal word
`define HPWS_LANE_LO        2'h0
`define HPWS_LANE_HI        2'h2

// ==========================================================
// reset level of the synchronised control pins: cs, strobe, dir, width, style
// all high, so the first cycles after reset never look like a strobe
`define HPWS_CTRL_IDLE      5'h1f

// ==========================================================
// data bus enables per access width
`define HPWS_OE_WORD        16'hffff
`define HPWS_OE_BYTE        16'h00ff

// ==========================================================
// synchroniser depth and clock rate
`define HPWS_SYNC_STAGES    2
`define HPWS_CLK_MHZ        100

`endif

// File: src/hpws_sync.v
// two flip-flop synchroniser for a bundle of asynchronous pin levels
// assumes pins are quasi-static relative to the core clock; no logic may read stage one
`timescale 1ns/1ns

module hpws_sync #(
  parameter             WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             ref_clk_i,
  input  wire             rst_n_i,
  // levels in and out
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  // ==========================================================
  // two stages
  reg [WIDTH-1:0] meta_ff;  // first stage, may go metastable
  reg [WIDTH-1:0] sync_ff;  // second stage, the only one read

  // reset to the idle level so no false edge follows reset
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

// File: src/hpws_top.v
// host port front end: strap handling, strobe decoding, lane steering to a 32-bit core bus
// assumes an outside pad ring resolves the data bus and the open ready/ack pin from enables
`timescale 1ns/1ns
`include "hpws_defs.vh"

// Operation
// - high style select gives split strobes
// - low style select gives data strobe
// - control pins remapped per selected style
// - acknowledge is ready high or ack low
// - high width select gives 16-bit words
// - low width select gives bytes on D7..0
// - low address and width pick lane
// - every strobe synchronised before use
module hpws_top (
  // clock and reset
  input  wire                     ref_clk_i,
  input  wire                     rst_n_i,
  // host pins
  input  wire [`HPWS_ADDR_W-1:0]  addr_i,
  input  wire [`HPWS_DATA_W-1:0]  data_i,
  output reg  [`HPWS_DATA_W-1:0]  data_o,
  output reg  [`HPWS_DATA_W-1:0]  data_oe_o,
  input  wire                     chip_select_n_i,
  input  wire                     read_or_data_strobe_n_i,
  input  wire                     write_or_direction_i,
  input  wire                     access_width_select_i,
  input  wire                     handshake_style_select_i,
  output wire                     cycle_acknowledge_o,
  // core side
  output reg  [`HPWS_ADDR_W-1:0]  core_addr_o,
  output reg  [`HPWS_INT_W-1:0]   core_wdata_o,
  output reg  [3:0]               core_be_o,
  output wire                     core_req_o,
  output reg                      core_we_o,
  input  wire [`HPWS_INT_W-1:0]   core_rdata_i,
  input  wire                     core_ack_i
);

  // ==========================================================
  // local encodings

  // cycle tracker states
  localparam [1:0] ST_IDLE  = 2'h0;  // no cycle, bus released
  localparam [1:0] ST_REQ   = 2'h1;  // core request open
  localparam [1:0] ST_HOLD  = 2'h2;  // answer given, strobe still active
  localparam [1:0] ST_SPARE = 2'h3;  // unused code, falls back to idle

  // bundle of synchronised pins: address, data, then five control levels
  localparam              SYNC_W   = `HPWS_ADDR_W + `HPWS_DATA_W + 5;
  localparam [SYNC_W-1:0] SYNC_RST = {{(SYNC_W-5){1'b0}}, `HPWS_CTRL_IDLE};

  // ==========================================================
  // helper functions

  // byte enables of one host access inside the core word
  function [3:0] lane_be;
    input       width_word;  // 1: 16-bit access, 0: 8-bit access
    input [1:0] lane;        // two lowest address bits
    begin
      if (width_word) begin
        // word access: bit 1 picks the half, bit 0 is ignored
        lane_be = lane[1] ? 4'hc : 4'h3;
      end else begin
        // byte access: one enable per address
        lane_be = 4'h1 << lane;
      end
    end
  endfunction

  // steer one lane of the core word down to the host bus
  function [`HPWS_DATA_W-1:0] pick_read;
    input [`HPWS_INT_W-1:0] word;        // core read word
    input                   width_word;  // 1: word, 0: byte
    input [1:0]             lane;        // two lowest address bits
    begin
      if (width_word) begin
        pick_read = lane[1] ? word[31:16] : word[15:0];
      end else begin
        // upper host lines stay zero in byte mode
        case (lane)
          2'h0: begin
            pick_read = {8'h00, word[7:0]};
          end
          2'h1: begin
            pick_read = {8'h00, word[15:8]};
          end
          2'h2: begin
            pick_read = {8'h00, word[23:16]};
          end
          default: begin
            pick_read = {8'h00, word[31:24]};
          end
        endcase
      end
    end
  endfunction

  // copy host write data onto every lane; the enables pick the live one
  function [`HPWS_INT_W-1:0] spread_write;
    input [`HPWS_DATA_W-1:0] d;           // host write data
    input                    width_word;  // 1: word, 0: byte
    begin
      if (width_word) begin
        spread_write = {d, d};
      end else begin
        spread_write = {4{d[7:0]}};
      end
    end
  endfunction

  // ==========================================================
  // pin synchronisation

  wire [SYNC_W-1:0] pins_async;  // raw host levels
  wire [SYNC_W-1:0] pins_sync;   // levels after two flops

  // address and data go through too, so nothing reads a raw host level
  assign pins_async = {addr_i,
                       data_i,
                       chip_select_n_i,
                       read_or_data_strobe_n_i,
                       write_or_direction_i,
                       access_width_select_i,
                       handshake_style_select_i};

  // costs two cycles of latency on every strobe edge
  hpws_sync #(
    .WIDTH   (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) sync_u (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (pins_async),
    .sync_o    (pins_sync)
  );

  // ==========================================================
  // bundle fields

  wire [`HPWS_ADDR_W-1:0] s_addr;      // address
  wire [`HPWS_DATA_W-1:0] s_data;      // write data
  wire                    s_cs_n;      // chip select, active low
  wire                    s_strobe_n;  // read strobe or data strobe
  wire                    s_dir;       // write strobe or direction
  wire                    s_width;     // 1: word, 0: byte
  wire                    s_style;     // 1: split strobes, 0: data strobe

  assign s_addr     = pins_sync[SYNC_W-1 -: `HPWS_ADDR_W];
  assign s_data     = pins_sync[`HPWS_DATA_W+4:5];
  assign s_cs_n     = pins_sync[4];
  assign s_strobe_n = pins_sync[3];
  assign s_dir      = pins_sync[2];
  assign s_width    = pins_sync[1];
  assign s_style    = pins_sync[0];

  // ==========================================================
  // strobe decoding

  reg read_act;   // a qualified read is on the pins
  reg write_act;  // a qualified write is on the pins

  // the control pins mean different things per style
  always @* begin
    read_act  = 1'b0;
    write_act = 1'b0;
    // nothing counts without chip select
    if (!s_cs_n) begin
      if (s_style == `HPWS_STYLE_SPLIT) begin
        // separate read and write strobes, read wins a clash
        read_act  = !s_strobe_n;
        write_act = s_strobe_n && !s_dir;
      end else begin
        // data strobe qualified by the direction line
        read_act  = !s_strobe_n && s_dir;
        write_act = !s_strobe_n && !s_dir;
      end
    end
  end

  wire cycle_act;  // some cycle is on the pins
  assign cycle_act = read_act | write_act;

  // ==========================================================
  // cycle tracker

  reg [1:0] state_ff;   // current state
  reg [1:0] nxt_state;  // next state
  reg       width_ff;   // width latched at cycle start
  reg [1:0] lane_ff;    // lane latched at cycle start

  wire start_cyc;  // idle and a cycle appears
  wire core_done;  // core answers the open request
  assign start_cyc = (state_ff == ST_IDLE) && cycle_act;
  assign core_done = (state_ff == ST_REQ) && core_ack_i;

  // one core request per host strobe; a new one needs the strobe released
  // limitation: a release shorter than one clock period may be missed, and one before the core answers is not seen
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (cycle_act) begin
          nxt_state = ST_REQ;
        end
      end
      ST_REQ: begin
        // never abandoned, so a short strobe still completes in the core
        if (core_ack_i) begin
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!cycle_act) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // core request

  // request fields frozen at cycle start, so the pins may move afterwards
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_addr_o  <= {`HPWS_ADDR_W{1'b0}};
      core_we_o    <= 1'b0;
      core_be_o    <= 4'h0;
      core_wdata_o <= {`HPWS_INT_W{1'b0}};
      width_ff     <= `HPWS_WIDTH_WORD;
      lane_ff      <= `HPWS_LANE_LO;
    end else if (start_cyc) begin
      // core sees the word address; lanes come from the enables
      core_addr_o  <= {s_addr[`HPWS_ADDR_W-1:2], 2'h0};
      core_we_o    <= write_act && !read_act;
      core_be_o    <= lane_be(s_width, s_addr[1:0]);
      core_wdata_o <= spread_write(s_data, s_width);
      width_ff     <= s_width;
      lane_ff      <= s_addr[1:0];
    end
  end

  // request stands until the core acknowledges
  assign core_req_o = (state_ff == ST_REQ);

  // ==========================================================
  // host data bus

  // drive only on reads, and release as soon as the strobe is gone
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o    <= {`HPWS_DATA_W{1'b0}};
      data_oe_o <= {`HPWS_DATA_W{1'b0}};
    end else if (core_done && !core_we_o && cycle_act) begin
      // upper lines stay released in byte mode
      data_o    <= pick_read(core_rdata_i, width_ff, lane_ff);
      data_oe_o <= width_ff ? `HPWS_OE_WORD : `HPWS_OE_BYTE;
    end else if (!cycle_act) begin
      data_oe_o <= {`HPWS_DATA_W{1'b0}};
    end
  end

  // ==========================================================
  // cycle acknowledge

  // split style: ready, low while the core request is open
  // data-strobe style: acknowledge, low while the answer stands
  // limitation: ready is high until the synchronised strobe is seen
  assign cycle_acknowledge_o = (s_style == `HPWS_STYLE_SPLIT) ? (state_ff != ST_REQ)
                                                              : (state_ff != ST_HOLD);

endmodule

// File: verif/hpws_host.sv
// host model: drives chip select and the two control pins in either style
// assumes the bench holds address, data and width itself
`timescale 1ns/1ns

module hpws_host (
  // clock
  input  wire logic clk_i,
  // bench command
  input  wire logic go_i,     // hold a cycle open
  input  wire logic rnw_i,    // 1: read, 0: write
  input  wire logic style_i,  // 1: split strobes, 0: data strobe
  // host pins
  output logic      cs_n_o,
  output logic      strobe_n_o,
  output logic      dir_o
);

  // pins move on the falling edge, away from the sampling edge
  always @(negedge clk_i) begin
    cs_n_o <= !go_i;
    if (!go_i) begin
      strobe_n_o <= 1'b1;
      dir_o      <= 1'b1;
    end else if (style_i) begin
      strobe_n_o <= !rnw_i;
      dir_o      <= rnw_i;
    end else begin
      strobe_n_o <= 1'b0;
      dir_o      <= rnw_i;
    end
  end

endmodule

// File: verif/hpws_monitor.sv
// checker for the host port front end, watching top-level ports only
// assumes one clock; reset disables every property
`timescale 1ns/1ns

module hpws_monitor (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        chip_select_n_i,
  input wire logic        access_width_select_i,
  input wire logic        handshake_style_select_i,
  input wire logic        core_ack_i,
  input wire logic        core_req_o,
  input wire logic        core_we_o,
  input wire logic [3:0]  core_be_o,
  input wire logic        cycle_acknowledge_o,
  input wire logic [15:0] data_oe_o
);
  default clocking @(posedge ref_clk_i);endclocking
  default disable iff(!rst_n_i);
  property p_idle;chip_select_n_i[*4]|->data_oe_o==16'h0;endproperty
  a_idle:assert property(p_idle)else $error("bus driven idle");
  property p_byte;(!access_width_select_i)[*4]|->data_oe_o[15:8]==8'h0;endproperty
  a_byte:assert property(p_byte)else $error("upper lane driven");
  property p_ack_split;
    (handshake_style_select_i && chip_select_n_i && core_ack_i)[*5] |-> cycle_acknowledge_o;
  endproperty
  a_ack_split:assert property(p_ack_split)else $error("ready low when idle");
  property p_ack_ds;
    (!handshake_style_select_i && chip_select_n_i && core_ack_i)[*5] |-> cycle_acknowledge_o;
  endproperty
  a_ack_ds:assert property(p_ack_ds)else $error("acknowledge low when idle");
  property p_req_hold;core_req_o && !core_ack_i |=> core_req_o;endproperty
  a_req_hold:assert property(p_req_hold)else $error("core request dropped");
  property p_oe_read;data_oe_o!=16'h0 |-> !core_we_o;endproperty
  a_oe_read:assert property(p_oe_read)else $error("bus driven on a write");
  property p_be;core_req_o |-> core_be_o inside {4'h1,4'h2,4'h4,4'h8,4'h3,4'hc};endproperty
  a_be:assert property(p_be)else $error("illegal lane enables");
  property p_oe_width;data_oe_o!=16'h0 |-> data_oe_o inside {16'hffff,16'h00ff};endproperty
  a_oe_width:assert property(p_oe_width)else $error("partial lane driven");
endmodule
bind hpws_top hpws_monitor monitor_u(.*);

// File: verif/host_port_protocol_width_select_tb_top.sv
// bench: corner and random host cycles in both styles, with a random core answer
// assumes each cycle reaches the core within sixty cycles
`timescale 1ns/1ns
module host_port_protocol_width_select_tb_top;
  logic c=0,rst_n=0,style=1,w=1,g=0,rnw=1,ack=0;logic [19:0] a=0;logic [15:0] wd=0;
  logic [31:0] r=7,ack_seed=7,ack_next;wire cs,rs,dir,cyc_ack,c_req,c_we;
  wire [15:0] d,oe;wire [19:0] c_addr;wire [31:0] c_wdata;wire [3:0] c_be;
  logic [19:0] cap_addr;logic [31:0] cap_wdata;logic [3:0] cap_be;logic cap_we;
  int n_mismatch=0,checks_done=0,k,i,ph,cap_cnt=0,last_cnt;
  always #5 c=~c;
  function logic [31:0] lfsr(logic [31:0] v);return {v[30:0],v[31]^v[21]^v[1]^v[0]};endfunction
  function logic [3:0] exp_be(logic ww,logic [1:0] l);
    return ww?(l[1]?4'hc:4'h3):(4'h1<<l);
  endfunction
  function logic [15:0] exp_rd(logic [31:0] v,logic ww,logic [1:0] l);
    return ww?(l[1]?v[31:16]:v[15:0]):{8'h00,v[8*l+:8]};
  endfunction
  function logic [31:0] msk(logic [3:0] b);return {{8{b[3]}},{8{b[2]}},{8{b[1]}},{8{b[0]}}};
  endfunction
  function logic [31:0] exp_wr(logic [15:0] v,logic ww);return ww?{v,v}:{4{v[7:0]}};endfunction
  hpws_host h_u(.clk_i(c),.go_i(g),.rnw_i(rnw),.style_i(style),.cs_n_o(cs),.strobe_n_o(rs),
    .dir_o(dir));
  hpws_top dut_u(.ref_clk_i(c),.rst_n_i(rst_n),.addr_i(a),.data_i(wd),.data_o(d),
    .data_oe_o(oe),.chip_select_n_i(cs),.read_or_data_strobe_n_i(rs),
    .write_or_direction_i(dir),.access_width_select_i(w),.handshake_style_select_i(style),
    .cycle_acknowledge_o(cyc_ack),.core_addr_o(c_addr),.core_wdata_o(c_wdata),.core_be_o(c_be),
    .core_req_o(c_req),.core_we_o(c_we),.core_rdata_i(r),.core_ack_i(ack));
  // core model: random acknowledge, captures what is handed over at that edge
  always @(negedge c) begin
    ack_next=lfsr(ack_seed);ack_seed<=ack_next;ack<=ack_next[3];
    if(c_req&&ack_next[3]) begin
      cap_addr<=c_addr;cap_wdata<=c_wdata;cap_be<=c_be;cap_we<=c_we;cap_cnt<=cap_cnt+1;
    end
  end
  task run_cycle(input int idx);
    @(negedge c);
    r=lfsr(r);wd=r[27:12];
    if(idx<8) begin w=idx[2];rnw=1;a={r[19:2],idx[1:0]};end // corner lanes
    else begin w=r[4];rnw=r[7];a=r[19:0];end // width moves with address
    g=1;last_cnt=cap_cnt;
    for(k=0;k<60&&cap_cnt==last_cnt;k++) @(negedge c);
    if(cap_cnt==last_cnt) begin
      n_mismatch++;$display("unexpected core request exp 1 got 0");complete_run();
    end
    repeat(2) @(negedge c);
    checks_done++;
    if(cap_we!==!rnw||cap_be!==exp_be(w,a[1:0])||cap_addr[19:2]!==a[19:2]) begin
      n_mismatch++;$display("unexpected core_be_o exp %h got %h",exp_be(w,a[1:0]),cap_be);
    end
    checks_done++;
    if(rnw) begin
      if({oe,d&oe}!=={w?16'hffff:16'h00ff,exp_rd(r,w,a[1:0])}) begin
        n_mismatch++;$display("unexpected data_o exp %h got %h",exp_rd(r,w,a[1:0]),d&oe);
      end
    end else if(oe!==16'h0||(cap_wdata&msk(cap_be))!==(exp_wr(wd,w)&msk(cap_be))) begin
      n_mismatch++;$display("unexpected core_wdata_o exp %h got %h",exp_wr(wd,w),cap_wdata);
    end
    checks_done++;
    if(cyc_ack!==style) begin
      n_mismatch++;$display("unexpected cycle_acknowledge_o exp %b got %b",style,cyc_ack);
    end
    g=0;
    repeat(8) @(negedge c);
    checks_done++;
    if(oe!==16'h0||cyc_ack!==1'b1) begin
      n_mismatch++;$display("unexpected data_oe_o exp 0 got %h",oe);
    end
    $display("test %0d style %0d done",idx,style);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d",checks_done,n_mismatch);
    if(n_mismatch==0&&checks_done>0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    // split style first, then a mid-run reset into data-strobe style
    for(ph=0;ph<2;ph++) begin
      rst_n=0;style=(ph==0); // style moves only under reset
      repeat(20) @(negedge c);
      rst_n=1;
      repeat(4) @(negedge c);
      checks_done++;
      if(oe!==16'h0||cyc_ack!==1'b1) begin
        n_mismatch++;$display("unexpected cycle_acknowledge_o exp 1 got %b",cyc_ack);
      end
      for(i=0;i<16;i++) run_cycle(i);
    end
    complete_run();
  end
endmodule
